/* logic/icsr_top.sv */
// Interrupt control and status registers with APB slave
//
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "icsr_params.svh"

// Behaviour
// - The priority extension bit reads 1 when the CPU priority exceeds 7, else 0.
// - CPU priority is the extension bit above the three low status-register bits.
// - Control-one bit 15 set disables nesting; clear permits it; resets to 0.
// - Bits 14 and 13 flag a trap caused by accumulator A or B overflow.
// - Bits 10, 9, 8 enable overflow traps of A, B and catastrophic overflow.
// - Control-one bits 3, 2, 1 read 1 after address, stack, oscillator traps.
// - Each request flag reads 1 once its source requested; all reset to 0.
// - Unimplemented bit positions read as 0.
// - Flag register zero holds the listed sources from bit 0 upward.
// - Flag register one holds the listed sources from bit 0 upward, bit 2 reserved.
// - Flags are set by events and cleared by software writes.
// - The extension bit is read-only to software; while 1 user interrupts are off.
// - While nesting is disabled the three low priority bits are read-only.
// - Control two holds edge polarity and alternate vector table select.
module icsr_top
  import icsr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] srcEvent0,
  input  wire logic [15:0] srcEvent1,
  input  wire logic [4:0]  extPin,
  input  wire logic        accAOverflow,
  input  wire logic        accBOverflow,
  input  wire logic        accACatastrophic,
  input  wire logic        accBCatastrophic,
  input  wire logic        addressErrorEvt,
  input  wire logic        stackErrorEvt,
  input  wire logic        oscFailureEvt,
  input  wire logic        trapEntry,
  input  wire logic        disableIrqInstrActive,
  output logic             accTrapReq,
  output logic             nestingDisable,
  output logic             alternateVectorSelect,
  output logic [3:0]       cpuPriority,
  output logic             userIrqDisabled,
  output logic [15:0]      cpuReq0,
  output logic [15:0]      cpuReq1,
  output logic             irq
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  icsr_word_t      ctrl1_reg, ctrl1_next;
  icsr_word_t      ctrl2_reg, ctrl2_next;
  icsr_word_t      flags0_reg, flags0_next;
  icsr_word_t      flags1_reg, flags1_next;
  icsr_word_t      enable0_reg, enable0_next;
  icsr_word_t      enable1_reg, enable1_next;
  logic [2:0]      priLow_reg, priLow_next;
  logic            priExt_reg, priExt_next;
  logic [1:0]      irqStat_reg, irqStat_next;
  logic [1:0]      irqMask_reg, irqMask_next;
  logic [31:0]     rdata_reg, rdata_next;
  logic            err_reg, err_next;
  icsr_bus_state_t state_reg, state_next;
  logic [4:0]      extEdge;
  logic            wrEn;
  logic            rdEn;
  logic            hit;
  logic [31:0]     rdMux;
  logic            newReq;
  logic            trapEvt;

  // Masked write of a 16-bit register
  function automatic icsr_word_t mwrite(icsr_word_t cur, icsr_word_t wd, icsr_word_t msk);
    mwrite = (cur & ~msk) | (wd & msk);
  endfunction

  // Software masked write then hardware set (set wins)
  function automatic icsr_word_t flagUpd(icsr_word_t cur, icsr_word_t wd, logic we,
                                         icsr_word_t msk, icsr_word_t setv);
    icsr_word_t v;
    v = cur;
    if (we)
      v = mwrite(cur, wd, msk);
    flagUpd = (v | setv) & msk;
  endfunction

  // ----------------------------------------
  // External pin edges
  // ----------------------------------------
  icsr_edge_detect #(.N(`ICSR_NUM_EXT)) uEdge (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .pinIn     (extPin),
    .fallSel   (ctrl2_reg[4:0]),
    .edgePulse (extEdge)
  );

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign wrEn = psel && penable && pwrite && (state_reg == ICSR_ACCESS);
  assign rdEn = psel && penable && !pwrite && (state_reg == ICSR_ACCESS);
  assign pready = (state_reg == ICSR_ACCESS);
  assign prdata = rdata_reg;
  assign pslverr = err_reg;

  // Read mux with unimplemented bits at zero
  always_comb
  begin
    hit = 1'b1;
    rdMux = 32'h0000_0000;
    unique case (paddr)
      `ICSR_OFF_CTRL1:   rdMux = {16'h0000, ctrl1_reg & `ICSR_CTRL1_WMASK};
      `ICSR_OFF_CTRL2:   rdMux = {16'h0000, ctrl2_reg[15], disableIrqInstrActive,
                                  9'h000, ctrl2_reg[4:0]};
      `ICSR_OFF_FLAGS0:  rdMux = {16'h0000, flags0_reg};
      `ICSR_OFF_FLAGS1:  rdMux = {16'h0000, flags1_reg};
      `ICSR_OFF_ENABLE0: rdMux = {16'h0000, enable0_reg};
      `ICSR_OFF_ENABLE1: rdMux = {16'h0000, enable1_reg};
      `ICSR_OFF_CPUPRI:  rdMux = {28'h0000000, priExt_reg, priLow_reg};
      `ICSR_OFF_IRQSTAT: rdMux = {30'h00000000, irqStat_reg};
      `ICSR_OFF_IRQMASK: rdMux = {30'h00000000, irqMask_reg};
      default:           hit = 1'b0;
    endcase
  end

  // Bus state, read data and error
  always_comb
  begin
    state_next = state_reg;
    rdata_next = rdata_reg;
    err_next = 1'b0;
    unique case (state_reg)
      ICSR_IDLE:
      begin
        if (psel && !penable)
        begin
          state_next = ICSR_ACCESS;
          rdata_next = rdMux;
          err_next = !hit;
        end
      end
      ICSR_ACCESS:
      begin
        state_next = ICSR_IDLE;
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  assign trapEvt = (accAOverflow && ctrl1_reg[`ICSR_CTRL1_ACC_A_OVERFLOW_TRAP_EN])
                 || (accBOverflow && ctrl1_reg[`ICSR_CTRL1_ACC_B_OVERFLOW_TRAP_EN])
                 || ((accACatastrophic || accBCatastrophic)
                     && ctrl1_reg[`ICSR_CTRL1_CATASTROPHIC_TRAP_EN]);

  always_comb
  begin
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    if (wrEn && paddr == `ICSR_OFF_CTRL1)
      ctrl1_next = mwrite(ctrl1_reg, pwdata[15:0], `ICSR_CTRL1_WMASK);
    if (wrEn && paddr == `ICSR_OFF_CTRL2)
      ctrl2_next = mwrite(ctrl2_reg, pwdata[15:0], `ICSR_CTRL2_WMASK);
    // Accumulator cause flags follow each accumulator trap
    if (trapEvt)
    begin
      ctrl1_next[`ICSR_CTRL1_OVA]  = accAOverflow && ctrl1_reg[`ICSR_CTRL1_ACC_A_OVERFLOW_TRAP_EN];
      ctrl1_next[`ICSR_CTRL1_OVB]  = accBOverflow && ctrl1_reg[`ICSR_CTRL1_ACC_B_OVERFLOW_TRAP_EN];
      ctrl1_next[`ICSR_CTRL1_COVA] = accACatastrophic && ctrl1_reg[`ICSR_CTRL1_CATASTROPHIC_TRAP_EN];
      ctrl1_next[`ICSR_CTRL1_COVB] = accBCatastrophic && ctrl1_reg[`ICSR_CTRL1_CATASTROPHIC_TRAP_EN];
    end
    // Trap status flags, set wins over clear
    if (addressErrorEvt)
      ctrl1_next[`ICSR_CTRL1_ADDR] = 1'b1;
    if (stackErrorEvt)
      ctrl1_next[`ICSR_CTRL1_STACK] = 1'b1;
    if (oscFailureEvt)
      ctrl1_next[`ICSR_CTRL1_OSC] = 1'b1;
    ctrl1_next = ctrl1_next & `ICSR_CTRL1_WMASK;
    ctrl2_next = ctrl2_next & `ICSR_CTRL2_WMASK;
  end

  // ----------------------------------------
  // CPU priority level
  // ----------------------------------------
  always_comb
  begin
    priLow_next = priLow_reg;
    priExt_next = priExt_reg;
    if (wrEn && paddr == `ICSR_OFF_CPUPRI && !ctrl1_reg[`ICSR_CTRL1_NESTDIS])
      priLow_next = pwdata[2:0];
    // Extension bit is hardware-only
    if (trapEntry || trapEvt || addressErrorEvt || stackErrorEvt || oscFailureEvt)
      priExt_next = 1'b1;
    else if (wrEn && paddr == `ICSR_OFF_CPUPRI && !pwdata[3])
      priExt_next = priExt_reg;
  end

  assign cpuPriority = {priExt_reg, priLow_reg};
  assign userIrqDisabled = (cpuPriority > `ICSR_PRI_MAX_LOW);
  assign nestingDisable = ctrl1_reg[`ICSR_CTRL1_NESTDIS];
  assign alternateVectorSelect = ctrl2_reg[`ICSR_CTRL2_ALTVT];
  assign accTrapReq = trapEvt;

  // ----------------------------------------
  // Request flags and enables
  // ----------------------------------------
  always_comb
  begin
    icsr_word_t set0;
    icsr_word_t set1;
    set0 = srcEvent0;
    set1 = srcEvent1;
    set0[0] = set0[0] | extEdge[0];
    set1[`ICSR_EXT1_BIT] = set1[`ICSR_EXT1_BIT] | extEdge[1];
    set1[`ICSR_EXT2_BIT] = set1[`ICSR_EXT2_BIT] | extEdge[2];
    flags0_next = flagUpd(flags0_reg, pwdata[15:0], wrEn && paddr == `ICSR_OFF_FLAGS0,
                          `ICSR_FLAGS0_WMASK, set0);
    flags1_next = flagUpd(flags1_reg, pwdata[15:0], wrEn && paddr == `ICSR_OFF_FLAGS1,
                          `ICSR_FLAGS1_WMASK, set1);
    enable0_next = enable0_reg;
    enable1_next = enable1_reg;
    if (wrEn && paddr == `ICSR_OFF_ENABLE0)
      enable0_next = pwdata[15:0] & `ICSR_FLAGS0_WMASK;
    if (wrEn && paddr == `ICSR_OFF_ENABLE1)
      enable1_next = pwdata[15:0] & `ICSR_FLAGS1_WMASK;
  end

  // Gate requests each cycle
  assign cpuReq0 = flags0_reg & enable0_reg;
  assign cpuReq1 = flags1_reg & enable1_reg;

  // ----------------------------------------
  // Summary interrupt, read clears status
  // ----------------------------------------
  assign newReq = (|(flags0_next & enable0_next & ~flags0_reg))
                || (|(flags1_next & enable1_next & ~flags1_reg));

  always_comb
  begin
    irqStat_next = irqStat_reg;
    irqMask_next = irqMask_reg;
    if (rdEn && paddr == `ICSR_OFF_IRQSTAT)
      irqStat_next = 2'b00;
    if (wrEn && paddr == `ICSR_OFF_IRQMASK)
      irqMask_next = pwdata[1:0];
    irqStat_next[0] = irqStat_next[0] | newReq;
    irqStat_next[1] = irqStat_next[1] | trapEvt | addressErrorEvt | stackErrorEvt
                    | oscFailureEvt;
  end

  assign irq = |(irqStat_reg & irqMask_reg);

  // ----------------------------------------
  // Register update
  // ----------------------------------------
  // Bus state, read data and error
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
      state_reg <= ICSR_IDLE;
    end
    else
    begin
      rdata_reg <= rdata_next;
      err_reg   <= err_next;
      state_reg <= state_next;
    end
  end

  // Control registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ctrl1_reg <= `ICSR_RESET16;
      ctrl2_reg <= `ICSR_RESET16;
    end
    else
    begin
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
    end
  end

  // CPU priority level
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      priLow_reg <= 3'h0;
      priExt_reg <= 1'b0;
    end
    else
    begin
      priLow_reg <= priLow_next;
      priExt_reg <= priExt_next;
    end
  end

  // Request flags and enables
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      flags0_reg  <= `ICSR_RESET16;
      flags1_reg  <= `ICSR_RESET16;
      enable0_reg <= `ICSR_RESET16;
      enable1_reg <= `ICSR_RESET16;
    end
    else
    begin
      flags0_reg  <= flags0_next;
      flags1_reg  <= flags1_next;
      enable0_reg <= enable0_next;
      enable1_reg <= enable1_next;
    end
  end

  // Summary status and mask
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      irqStat_reg <= 2'h0;
      irqMask_reg <= 2'h0;
    end
    else
    begin
      irqStat_reg <= irqStat_next;
      irqMask_reg <= irqMask_next;
    end
  end
endmodule
`default_nettype wire

/* logic/icsr_params.svh */
// Offsets, field positions, reset values for the interrupt control/status block
`ifndef ICSR_PARAMS_SVH
`define ICSR_PARAMS_SVH
`define ICSR_OFF_CTRL1     12'h000
`define ICSR_OFF_CTRL2     12'h004
`define ICSR_OFF_FLAGS0    12'h008
`define ICSR_OFF_FLAGS1    12'h00c
`define ICSR_OFF_ENABLE0   12'h010
`define ICSR_OFF_ENABLE1   12'h014
`define ICSR_OFF_CPUPRI    12'h018
`define ICSR_OFF_IRQSTAT   12'h01c
`define ICSR_OFF_IRQMASK   12'h020
`define ICSR_CTRL1_NESTDIS 15
`define ICSR_CTRL1_OVA     14
`define ICSR_CTRL1_OVB     13
`define ICSR_CTRL1_COVA    12
`define ICSR_CTRL1_COVB    11
`define ICSR_CTRL1_ACC_A_OVERFLOW_TRAP_EN   10
`define ICSR_CTRL1_ACC_B_OVERFLOW_TRAP_EN   9
`define ICSR_CTRL1_CATASTROPHIC_TRAP_EN   8
`define ICSR_CTRL1_ADDR    3
`define ICSR_CTRL1_STACK   2
`define ICSR_CTRL1_OSC     1
`define ICSR_CTRL1_WMASK   16'hfffe
`define ICSR_CTRL2_ALTVT   15
`define ICSR_CTRL2_DISABLE_IRQ_INSTR_ACTIVE    14
`define ICSR_CTRL2_WMASK   16'h801f
`define ICSR_FLAGS0_WMASK  16'h7fff
`define ICSR_FLAGS1_WMASK  16'hfffb
`define ICSR_RESET16       16'h0000
`define ICSR_PRI_MAX_LOW   4'h7
`define ICSR_NUM_EXT       5
`define ICSR_EXT1_BIT      4
`define ICSR_EXT2_BIT      13
`endif

/* logic/icsr_pkg.sv */
// Types for the interrupt control/status block
package icsr_pkg;
  typedef logic [15:0] icsr_word_t;
  typedef enum logic [1:0] {ICSR_IDLE, ICSR_ACCESS} icsr_bus_state_t;
endpackage

/* logic/icsr_edge_detect.sv */
// Edge detector with polarity select for external request pins
`timescale 1ns/1ps
`default_nettype none
module icsr_edge_detect
  import icsr_pkg::*;
#(
  parameter int N = 5
)(
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] pinIn,
  input  wire logic [N-1:0] fallSel,
  output logic      [N-1:0] edgePulse
);
  logic [N-1:0] prev_reg;
  logic [N-1:0] prev_next;

  // ----------------------------------------
  // Edge selection
  // ----------------------------------------
  always_comb
  begin
    prev_next = pinIn;
    edgePulse = (fallSel & prev_reg & ~pinIn) | (~fallSel & ~prev_reg & pinIn);
  end

  // Previous pin level, follows the pin through reset so release makes no false edge
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      prev_reg <= pinIn;
    else
      prev_reg <= prev_next;
  end
endmodule
`default_nettype wire

/* testbench/icsr_checker_asserts.sv */
// Port assertions for the interrupt control and status block
`timescale 1ns/1ps
`default_nettype none
module icsr_checker (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        accAOverflow,
  input wire logic        accBOverflow,
  input wire logic        accACatastrophic,
  input wire logic        accBCatastrophic,
  input wire logic        trapEntry,
  input wire logic        accTrapReq,
  input wire logic        nestingDisable,
  input wire logic [3:0]  cpuPriority,
  input wire logic        userIrqDisabled
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Level, gate and trap behaviour
  prio_over_seven_a:
    assert property (userIrqDisabled == (cpuPriority > 4'h7)) else $error("gate wrong");
  ext_bit_sticky_a:
    assert property (cpuPriority[3] |=> cpuPriority[3]) else $error("ext bit fell");
  trap_sets_ext_a:
    assert property (trapEntry |=> cpuPriority[3]) else $error("trap level low");
  nest_low_hold_a:
    assert property (nestingDisable |=> $stable(cpuPriority[2:0])) else $error("low bits moved");
  acc_trap_idle_a:
    assert property (!(accAOverflow || accBOverflow || accACatastrophic || accBCatastrophic)
      |-> !accTrapReq) else $error("spurious trap");
  // Bus answer timing and data
  setup_ready_a:
    assert property (psel && !penable |=> pready) else $error("no ready");
  quiet_idle_a:
    assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("bus not quiet");
  upper_zero_a:
    assert property (pready |-> prdata[31:16] == 16'h0) else $error("upper half set");
  unmapped_err_a:
    assert property (pready && paddr > 12'h020 |-> pslverr) else $error("no slverr");
endmodule
bind icsr_top icsr_checker icsr_checker_i (.core_clk, .rst_n, .psel, .penable, .paddr,
  .prdata, .pready, .pslverr, .accAOverflow, .accBOverflow, .accACatastrophic,
  .accBCatastrophic, .trapEntry, .accTrapReq, .nestingDisable, .cpuPriority,
  .userIrqDisabled);
`default_nettype wire

/* testbench/icsr_cpu_model.sv */
// CPU core model: enters a trap one cycle after a request
`timescale 1ns/1ps
`default_nettype none
module icsr_cpu_model (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic accTrapReq,
  output logic      trapEntry
);
  // Trap entry pulse follows each request
  always_ff @(posedge core_clk)
  begin
    trapEntry <= rst_n & accTrapReq;
  end
endmodule
`default_nettype wire

/* testbench/tb_interrupt_ctrl_status_regs.sv */
// Self-checking bench for the interrupt control and status block
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_ctrl_status_regs import icsr_pkg::*;;
  logic        core_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        accAOverflow, accBOverflow, accACatastrophic, accBCatastrophic;
  logic        addressErrorEvt, stackErrorEvt, oscFailureEvt, trapEntry, altVec;
  logic        disableIrqInstrActive, accTrapReq, nestingDisable, userIrqDisabled;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] srcEvent0, srcEvent1, cpuReq0, cpuReq1;
  logic [4:0]  extPin;
  logic [3:0]  cpuPriority;
  int          failCount = 0, nChecks = 0, cyc = 0;
  icsr_top icsr_top_i (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .srcEvent0, .srcEvent1, .extPin, .accAOverflow,
    .accBOverflow, .accACatastrophic, .accBCatastrophic, .addressErrorEvt,
    .stackErrorEvt, .oscFailureEvt, .trapEntry, .disableIrqInstrActive, .accTrapReq,
    .nestingDisable, .alternateVectorSelect(altVec), .cpuPriority, .userIrqDisabled,
    .cpuReq0, .cpuReq1, .irq);
  icsr_cpu_model icsr_cpu_model_i (.core_clk, .rst_n, .accTrapReq, .trapEntry);
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    nChecks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", nChecks, failCount);
    if (failCount == 0 && nChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One APB transfer; read data compared with x
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, x);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    if (!w) chk($sformatf("reg %h", a), prdata, x);
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask
  // Readable bits of the registers at 000 to 00c
  function automatic logic [31:0] rdMask(input logic [11:0] a, input logic [31:0] v);
    case (a)
      12'h000: return v & 32'hfffe;
      12'h004: return v & 32'h801f;
      12'h008: return v & 32'h7fff;
      default: return v & 32'hfffb;
    endcase
  endfunction
  // Clock and hang limit
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failCount++;
      tallyAndFinish();
    end
  end
  initial
  begin
    void'($urandom(94917));
    {core_clk, rst_n, psel, penable, pwrite, paddr, pwdata, extPin} = '0;
    {srcEvent0, srcEvent1, accAOverflow, accBOverflow, accACatastrophic} = '0;
    {accBCatastrophic, addressErrorEvt, stackErrorEvt, oscFailureEvt} = '0;
    disableIrqInstrActive = 1'h0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    // Reset values, then an unmapped word
    for (int a = 0; a <= 32; a += 4)
      bus(1'h0, a[11:0], 32'h0, 32'h0);
    bus(1'h0, 12'h024, 32'h0, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    // Random writes keep only implemented bits; zero clears
    repeat (3)
      for (int a = 0; a <= 12; a += 4)
      begin
        r = $urandom;
        bus(1'h1, a[11:0], r, 32'h0);
        bus(1'h0, a[11:0], 32'h0, rdMask(a[11:0], r));
        bus(1'h1, a[11:0], 32'h0, 32'h0);
        bus(1'h0, a[11:0], 32'h0, 32'h0);
      end
    disableIrqInstrActive <= 1'h1;
    bus(1'h0, 12'h004, 32'h0, 32'h4000);
    disableIrqInstrActive <= 1'h0;
    bus(1'h1, 12'h004, 32'h8000, 32'h0);
    chk("alt vector", {31'h0, altVec}, 32'h1);
    // Interrupt raised while masked, unmasked, then cleared
    bus(1'h1, 12'h010, 32'h2, 32'h0);
    srcEvent0 <= 16'h0002;
    @(posedge core_clk);
    srcEvent0 <= 16'h0000;
    repeat (3) @(posedge core_clk);
    chk("cpu req", {16'h0, cpuReq0}, 32'h2);
    chk("irq masked", {31'h0, irq}, 32'h0);
    bus(1'h1, 12'h020, 32'h1, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("irq", {31'h0, irq}, 32'h1);
    bus(1'h1, 12'h008, 32'h0, 32'h0);
    chk("cpu req", {16'h0, cpuReq0}, 32'h0);
    bus(1'h0, 12'h01c, 32'h0, 32'h1);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    bus(1'h1, 12'h010, 32'h0, 32'h0);
    // Source events set their flags
    r = $urandom;
    srcEvent0 <= r[15:0];
    srcEvent1 <= r[31:16];
    @(posedge core_clk);
    srcEvent0 <= 16'h0;
    srcEvent1 <= 16'h0;
    bus(1'h0, 12'h008, 32'h0, rdMask(12'h008, {16'h0, r[15:0]}));
    bus(1'h0, 12'h00c, 32'h0, rdMask(12'h00c, {16'h0, r[31:16]}));
    bus(1'h1, 12'h014, 32'hffff, 32'h0);
    chk("cpu req1", {16'h0, cpuReq1}, rdMask(12'h00c, {16'h0, r[31:16]}));
    bus(1'h1, 12'h014, 32'h0, 32'h0);
    // Pin edges per polarity: active edge flags, other edge not
    for (int p = 0; p < 2; p++)
    begin
      bus(1'h1, 12'h004, {27'h0, {5{p[0]}}}, 32'h0);
      extPin <= {5{p[0]}};
      repeat (3) @(posedge core_clk);
      bus(1'h1, 12'h008, 32'h0, 32'h0);
      bus(1'h1, 12'h00c, 32'h0, 32'h0);
      extPin <= ~{5{p[0]}};
      repeat (3) @(posedge core_clk);
      bus(1'h0, 12'h008, 32'h0, 32'h1);
      bus(1'h0, 12'h00c, 32'h0, 32'h2010);
      bus(1'h1, 12'h008, 32'h0, 32'h0);
      bus(1'h1, 12'h00c, 32'h0, 32'h0);
      extPin <= {5{p[0]}};
      repeat (3) @(posedge core_clk);
      bus(1'h0, 12'h008, 32'h0, 32'h0);
    end
    // Priority low bits, frozen while nesting is off
    bus(1'h1, 12'h018, 32'h5, 32'h0);
    bus(1'h0, 12'h018, 32'h0, 32'h5);
    chk("user gate", {31'h0, userIrqDisabled}, 32'h0);
    bus(1'h1, 12'h000, 32'h8000, 32'h0);
    chk("nesting", {31'h0, nestingDisable}, 32'h1);
    bus(1'h1, 12'h018, 32'h3, 32'h0);
    bus(1'h0, 12'h018, 32'h0, 32'h5);
    bus(1'h1, 12'h000, 32'h0, 32'h0);
    // Trap status bits; these also raise the extension bit
    {addressErrorEvt, stackErrorEvt, oscFailureEvt} <= 3'h7;
    @(posedge core_clk);
    {addressErrorEvt, stackErrorEvt, oscFailureEvt} <= 3'h0;
    bus(1'h0, 12'h000, 32'h0, 32'h000e);
    bus(1'h1, 12'h000, 32'h0, 32'h0);
    // Disabled then enabled accumulator overflow traps
    accBOverflow <= 1'h1;
    @(posedge core_clk);
    chk("trap req", {31'h0, accTrapReq}, 32'h0);
    accBOverflow <= 1'h0;
    bus(1'h0, 12'h000, 32'h0, 32'h0);
    bus(1'h1, 12'h000, 32'h0400, 32'h0);
    accAOverflow <= 1'h1;
    @(posedge core_clk);
    chk("trap req", {31'h0, accTrapReq}, 32'h1);
    accAOverflow <= 1'h0;
    bus(1'h0, 12'h000, 32'h0, 32'h4400);
    bus(1'h1, 12'h018, 32'h0, 32'h0);
    bus(1'h0, 12'h018, 32'h0, 32'h8);
    chk("user gate", {31'h0, userIrqDisabled}, 32'h1);
    chk("level", {28'h0, cpuPriority}, 32'h8);
    // Mid-run reset
    rst_n <= 1'h0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    bus(1'h0, 12'h018, 32'h0, 32'h0);
    bus(1'h0, 12'h008, 32'h0, 32'h0);
    bus(1'h0, 12'h00c, 32'h0, 32'h0);
    tallyAndFinish();
  end
endmodule
`default_nettype wire
